// ==== verilog/tcu_pkg.sv ====
package tcu_pkg;

   // Register addresses
   localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h88;
   localparam logic [7:0] ADDR_TIMER_MODE_CONTROL = 8'h89;
   localparam logic [7:0] ADDR_TIMER0_LOW_BYTE = 8'h8a;
   localparam logic [7:0] ADDR_TIMER1_LOW_BYTE = 8'h8b;
   localparam logic [7:0] ADDR_TIMER0_HIGH_BYTE = 8'h8c;
   localparam logic [7:0] ADDR_TIMER1_HIGH_BYTE = 8'h8d;
   localparam logic [7:0] ADDR_TIMER2_CONTROL = 8'hc8;
   localparam logic [7:0] ADDR_TIMER2_MODE_CONTROL = 8'hc9;
   localparam logic [7:0] ADDR_TIMER2_RELOAD_LOW = 8'hca;
   localparam logic [7:0] ADDR_TIMER2_RELOAD_HIGH = 8'hcb;
   localparam logic [7:0] ADDR_TIMER2_LOW_BYTE = 8'hcc;
   localparam logic [7:0] ADDR_TIMER2_HIGH_BYTE = 8'hcd;

   // Reset and all-ones values
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [15:0] COUNT_ALL_ONES = 16'hffff;

   // timer_control fields
   localparam int TC_TIMER1_OVERFLOW = 7;
   localparam int TC_TIMER1_RUN = 6;
   localparam int TC_TIMER0_OVERFLOW = 5;
   localparam int TC_TIMER0_RUN = 4;

   // timer_mode_control fields
   localparam int TM_TIMER1_GATE = 7;
   localparam int TM_TIMER1_COUNTER_SELECT = 6;
   localparam int TM_TIMER1_MODE_HI = 5;
   localparam int TM_TIMER1_MODE_LO = 4;
   localparam int TM_TIMER0_GATE = 3;
   localparam int TM_TIMER0_COUNTER_SELECT = 2;
   localparam int TM_TIMER0_MODE_HI = 1;
   localparam int TM_TIMER0_MODE_LO = 0;

   // timer2_control fields
   localparam int T2C_OVERFLOW = 7;
   localparam int T2C_EXT_FLAG = 6;
   localparam int T2C_RX_BAUD = 5;
   localparam int T2C_TX_BAUD = 4;
   localparam int T2C_EXT_EN = 3;
   localparam int T2C_RUN = 2;
   localparam int T2C_COUNTER_SELECT = 1;
   localparam int T2C_CAPTURE_SEL = 0;

   // timer2_mode_control fields
   localparam int T2M_OUT_EN = 1;
   localparam int T2M_UPDOWN_EN = 0;

   // Timer 0/1 mode codes
   localparam logic [1:0] MODE_13BIT = 2'h0;
   localparam logic [1:0] MODE_16BIT = 2'h1;
   localparam logic [1:0] MODE_RELOAD = 2'h2;
   localparam logic [1:0] MODE_SPLIT = 2'h3;

   // Clock division
   localparam int PERIPH_DIV = 6;
   localparam int CLKOUT_DIV = 2;
   localparam int PRESCALE_WIDTH = 5;

   // Synchronised pin indices
   localparam int PIN_IRQ0 = 0;
   localparam int PIN_IRQ1 = 1;
   localparam int PIN_CNT0 = 2;
   localparam int PIN_CNT1 = 3;
   localparam int PIN_CNT2 = 4;
   localparam int PIN_DIR2 = 5;
   localparam int PIN_COUNT = 6;

   typedef struct packed {
      logic [7:0] high;
      logic [7:0] low;
      logic ovf;
   } tcu_step_t;

endpackage : tcu_pkg

// ==== verilog/tcu_top.sv ====
// What this block does
// - Timer 1 runs when run bit set, and if gated only while irq1 pin high.
// - Timer 0 runs when run bit set, and if gated only while irq0 pin high.
// - Counter-select clear counts divided clock; set counts falling edges on count pin.
// - Timer 1 modes: 13-bit, 16-bit, 8-bit auto-reload, halted keeping count.
// - Timer 0 mode 3 splits into two 8-bit timers; high uses timer 1 run/flag.
// - Auto-reload mode reloads the low byte from the high byte on overflow.
// - Mode control and count byte registers reset to zero.
// - Timer 2 is a 16-bit count in cascaded low and high bytes.
// - Timer 2 counter-select picks clock divided by 6 (by 2 in baud or clock-out mode) or timer-2 pin.
// - Timer 2 increments only while its run bit is set.
// - With up/down enabled and capture select clear (or in baud mode), direction pin high counts up, low counts down.
// - Outside baud and clock-out modes, up-count overflow at FFFFh sets flag and requests interrupt; it loads reload pair unless capture select is set.
// - Down-count underflow at reload value loads FFFFh, and sets flag outside baud and clock-out modes.
// - Up/down mode toggles external flag on each wrap, without interrupt.
// - Clock-out mode is 50% duty, low byte increments at clock divided by 2.
// - Clock-out overflow reloads from reload pair and raises no interrupt.
// - Clock-out frequency is clock over 4 times (65536 minus reload).
// - Clock-out square wave drives the timer-2 pin.
// - Baud generation and clock-out share the one reload pair.
// - 13-bit mode uses low five bits as modulo-32 prescaler into high byte.
// - Timer 0/1 overflow sets flag (timer 1 sets none while timer 0 is in mode 3); vectoring to the handler clears it.
// - Split-mode high byte counts clock divided by 6, borrowing timer 1 controls.
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
module tcu_top
   import tcu_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic timer0_irq_ack,
   input wire logic timer1_irq_ack,
   input wire logic ext_irq0_pin,
   input wire logic ext_irq1_pin,
   input wire logic timer0_count_pin,
   input wire logic timer1_count_pin,
   input wire logic timer2_clock_pin_in,
   output logic timer2_clock_pin_out,
   output logic timer2_clock_pin_oe_n,
   input wire logic timer2_direction_pin,
   output logic timer0_irq,
   output logic timer1_irq,
   output logic timer2_irq,
   output logic timer2_baud_tick
);

   logic rst_meta_reg, rst_sync_n;
   logic [PIN_COUNT-1:0] pin_raw, sync1_reg, sync2_reg, sync3_reg;
   logic [PIN_COUNT-1:0] pin_level_reg, pin_agree, pin_fall;
   logic [2:0] div6_reg;
   logic div6_tick, div2_reg;
   logic [7:0] timer_mode_control_reg, tl0_reg, th0_reg, tl1_reg, th1_reg, timer2_control_reg;
   logic tf0_reg, tf1_reg, tr0_reg, tr1_reg, clkout_reg;
   logic [1:0] timer2_mode_control_reg, mode0, mode1;
   logic [15:0] reload2_reg, count2_reg, count2_next;
   logic tick0, tick1, tick0_high, tick2, wrap2;
   tcu_step_t step0, step1;
   logic [7:0] tl0_next, th0_next, tl1_next, th1_next, rdata_next;
   logic set_tf0, set_tf1, baud_mode, clkout_mode, count_down;

   function automatic tcu_step_t tcu_step(input logic [1:0] mode, input logic [7:0] low, input logic [7:0] high);
      tcu_step_t s;
      s.low = low;
      s.high = high;
      s.ovf = 1'b0;
      case (mode)
         MODE_13BIT:
         begin
            s.low[PRESCALE_WIDTH-1:0] = low[PRESCALE_WIDTH-1:0] + 5'h01;
            if (low[PRESCALE_WIDTH-1:0] == 5'h1f)
            begin
               s.high = high + 8'h01;
               s.ovf = (high == 8'hff);
            end
         end
         MODE_16BIT:
         begin
            {s.high, s.low} = {high, low} + 16'h0001;
            s.ovf = ({high, low} == COUNT_ALL_ONES);
         end
         MODE_RELOAD:
         begin
            if (low == 8'hff)
            begin
               s.low = high;
               s.ovf = 1'b1;
            end
            else
               s.low = low + 8'h01;
         end
         default:
            s.ovf = 1'b0;
      endcase
      return s;
   endfunction : tcu_step

   function automatic logic reg_hit(input logic strobe, input logic [7:0] addr, input logic [7:0] target);
      return strobe && (addr == target);
   endfunction : reg_hit

   // Reset release
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_meta_reg <= 1'b0;
         rst_sync_n <= 1'b0;
      end
      else
      begin
         rst_meta_reg <= 1'b1;
         rst_sync_n <= rst_meta_reg;
      end
   end

   // Pin synchronisers with agreement filter
   assign pin_raw = {timer2_direction_pin, timer2_clock_pin_in, timer1_count_pin,
                     timer0_count_pin, ext_irq1_pin, ext_irq0_pin};
   assign pin_agree = ~(sync2_reg ^ sync3_reg);
   assign pin_fall = pin_level_reg & ~sync3_reg & pin_agree;

   always_ff @(posedge ref_clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         sync1_reg <= '0;
         sync2_reg <= '0;
         sync3_reg <= '0;
         pin_level_reg <= '0;
      end
      else
      begin
         sync1_reg <= pin_raw;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
         pin_level_reg <= (pin_level_reg & ~pin_agree) | (sync3_reg & pin_agree);
      end
   end

   // Clock dividers
   assign div6_tick = (div6_reg == 3'(PERIPH_DIV - 1));

   always_ff @(posedge ref_clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         div6_reg <= 3'h0;
         div2_reg <= 1'b0;
      end
      else
      begin
         div6_reg <= div6_tick ? 3'h0 : div6_reg + 3'h1;
         div2_reg <= ~div2_reg;
      end
   end

   // Timers 0 and 1
   assign mode0 = timer_mode_control_reg[TM_TIMER0_MODE_HI:TM_TIMER0_MODE_LO];
   assign mode1 = timer_mode_control_reg[TM_TIMER1_MODE_HI:TM_TIMER1_MODE_LO];

   assign tick0 = tr0_reg
                  && (!timer_mode_control_reg[TM_TIMER0_GATE] || pin_level_reg[PIN_IRQ0])
                  && (timer_mode_control_reg[TM_TIMER0_COUNTER_SELECT] ? pin_fall[PIN_CNT0] : div6_tick);
   assign tick1 = tr1_reg
                  && (!timer_mode_control_reg[TM_TIMER1_GATE] || pin_level_reg[PIN_IRQ1])
                  && (timer_mode_control_reg[TM_TIMER1_COUNTER_SELECT] ? pin_fall[PIN_CNT1] : div6_tick);
   assign tick0_high = (mode0 == MODE_SPLIT) && tr1_reg && div6_tick;

   assign step0 = tcu_step(mode0, tl0_reg, th0_reg);
   assign step1 = tcu_step(mode1, tl1_reg, th1_reg);

   always_comb
   begin
      tl0_next = tl0_reg;
      th0_next = th0_reg;
      set_tf0 = 1'b0;
      set_tf1 = 1'b0;
      tl1_next = tl1_reg;
      th1_next = th1_reg;
      if (mode0 == MODE_SPLIT)
      begin
         if (tick0)
         begin
            tl0_next = tl0_reg + 8'h01;
            set_tf0 = (tl0_reg == 8'hff);
         end
         if (tick0_high)
         begin
            th0_next = th0_reg + 8'h01;
            set_tf1 = (th0_reg == 8'hff);
         end
      end
      else if (tick0)
      begin
         tl0_next = step0.low;
         th0_next = step0.high;
         set_tf0 = step0.ovf;
      end
      if (tick1)
      begin
         tl1_next = step1.low;
         th1_next = step1.high;
         if (mode0 != MODE_SPLIT)
         begin
            set_tf1 = step1.ovf;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         timer_mode_control_reg <= RESET_BYTE;
         tl0_reg <= RESET_BYTE;
         th0_reg <= RESET_BYTE;
         tl1_reg <= RESET_BYTE;
         th1_reg <= RESET_BYTE;
      end
      else
      begin
         if (reg_hit(reg_wr, reg_addr, ADDR_TIMER_MODE_CONTROL))
            timer_mode_control_reg <= reg_wdata;
         tl0_reg <= reg_hit(reg_wr, reg_addr, ADDR_TIMER0_LOW_BYTE) ? reg_wdata : tl0_next;
         th0_reg <= reg_hit(reg_wr, reg_addr, ADDR_TIMER0_HIGH_BYTE) ? reg_wdata : th0_next;
         tl1_reg <= reg_hit(reg_wr, reg_addr, ADDR_TIMER1_LOW_BYTE) ? reg_wdata : tl1_next;
         th1_reg <= reg_hit(reg_wr, reg_addr, ADDR_TIMER1_HIGH_BYTE) ? reg_wdata : th1_next;
      end
   end

   // Timer 0/1 run bits and flags; a hardware set wins over any clear
   always_ff @(posedge ref_clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         tf0_reg <= 1'b0;
         tf1_reg <= 1'b0;
         tr0_reg <= 1'b0;
         tr1_reg <= 1'b0;
      end
      else
      begin
         if (reg_hit(reg_wr, reg_addr, ADDR_TIMER_CONTROL))
         begin
            tr0_reg <= reg_wdata[TC_TIMER0_RUN];
            tr1_reg <= reg_wdata[TC_TIMER1_RUN];
            tf0_reg <= set_tf0 | reg_wdata[TC_TIMER0_OVERFLOW];
            tf1_reg <= set_tf1 | reg_wdata[TC_TIMER1_OVERFLOW];
         end
         else
         begin
            tf0_reg <= set_tf0 | (tf0_reg & ~timer0_irq_ack);
            tf1_reg <= set_tf1 | (tf1_reg & ~timer1_irq_ack);
         end
      end
   end

   // Timer 2
   assign baud_mode = timer2_control_reg[T2C_RX_BAUD] | timer2_control_reg[T2C_TX_BAUD];
   assign clkout_mode = timer2_mode_control_reg[T2M_OUT_EN] & ~timer2_control_reg[T2C_COUNTER_SELECT];
   assign count_down = timer2_mode_control_reg[T2M_UPDOWN_EN] && !pin_level_reg[PIN_DIR2]
                       && (!timer2_control_reg[T2C_CAPTURE_SEL] || baud_mode);

   assign tick2 = timer2_control_reg[T2C_RUN]
                  && (timer2_control_reg[T2C_COUNTER_SELECT] ? pin_fall[PIN_CNT2]
                      : ((clkout_mode || baud_mode) ? div2_reg : div6_tick));

   always_comb
   begin
      wrap2 = 1'b0;
      count2_next = count2_reg + 16'h0001;
      if (count_down)
      begin
         count2_next = count2_reg - 16'h0001;
         if (count2_reg == reload2_reg)
         begin
            wrap2 = 1'b1;
            count2_next = COUNT_ALL_ONES;
         end
      end
      else if (count2_reg == COUNT_ALL_ONES)
      begin
         wrap2 = 1'b1;
         if (!timer2_control_reg[T2C_CAPTURE_SEL] || baud_mode || clkout_mode)
            count2_next = reload2_reg;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         count2_reg <= 16'h0000;
         reload2_reg <= 16'h0000;
         timer2_mode_control_reg <= 2'h0;
      end
      else
      begin
         if (reg_hit(reg_wr, reg_addr, ADDR_TIMER2_LOW_BYTE))
            count2_reg[7:0] <= reg_wdata;
         else if (reg_hit(reg_wr, reg_addr, ADDR_TIMER2_HIGH_BYTE))
            count2_reg[15:8] <= reg_wdata;
         else if (tick2)
            count2_reg <= count2_next;
         if (reg_hit(reg_wr, reg_addr, ADDR_TIMER2_RELOAD_LOW))
            reload2_reg[7:0] <= reg_wdata;
         if (reg_hit(reg_wr, reg_addr, ADDR_TIMER2_RELOAD_HIGH))
            reload2_reg[15:8] <= reg_wdata;
         if (reg_hit(reg_wr, reg_addr, ADDR_TIMER2_MODE_CONTROL))
            timer2_mode_control_reg <= reg_wdata[1:0];
      end
   end

   // Timer 2 control, flags, clock-out and baud tick
   always_ff @(posedge ref_clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         timer2_control_reg <= RESET_BYTE;
         clkout_reg <= 1'b0;
         timer2_baud_tick <= 1'b0;
      end
      else
      begin
         if (reg_hit(reg_wr, reg_addr, ADDR_TIMER2_CONTROL))
            timer2_control_reg <= reg_wdata;
         if (tick2 && wrap2)
         begin
            if (!baud_mode && !clkout_mode)
               timer2_control_reg[T2C_OVERFLOW] <= 1'b1;
            if (timer2_mode_control_reg[T2M_UPDOWN_EN])
               timer2_control_reg[T2C_EXT_FLAG] <= ~timer2_control_reg[T2C_EXT_FLAG];
         end
         if (!clkout_mode)
            clkout_reg <= 1'b0;
         else if (tick2 && wrap2)
            clkout_reg <= ~clkout_reg;
         timer2_baud_tick <= tick2 && wrap2 && baud_mode;
      end
   end

   assign timer2_clock_pin_out = clkout_reg;
   assign timer2_clock_pin_oe_n = ~clkout_mode;
   assign timer0_irq = tf0_reg;
   assign timer1_irq = tf1_reg;
   assign timer2_irq = timer2_control_reg[T2C_OVERFLOW];

   // Read port
   always_comb
   begin
      rdata_next = 8'h00;
      if (reg_addr == ADDR_TIMER_CONTROL)
         rdata_next = {tf1_reg, tr1_reg, tf0_reg, tr0_reg, 4'h0};
      else if (reg_addr == ADDR_TIMER_MODE_CONTROL)
         rdata_next = timer_mode_control_reg;
      else if (reg_addr == ADDR_TIMER0_LOW_BYTE)
         rdata_next = tl0_reg;
      else if (reg_addr == ADDR_TIMER1_LOW_BYTE)
         rdata_next = tl1_reg;
      else if (reg_addr == ADDR_TIMER0_HIGH_BYTE)
         rdata_next = th0_reg;
      else if (reg_addr == ADDR_TIMER1_HIGH_BYTE)
         rdata_next = th1_reg;
      else if (reg_addr == ADDR_TIMER2_CONTROL)
         rdata_next = timer2_control_reg;
      else if (reg_addr == ADDR_TIMER2_MODE_CONTROL)
         rdata_next = {6'h00, timer2_mode_control_reg};
      else if (reg_addr == ADDR_TIMER2_RELOAD_LOW)
         rdata_next = reload2_reg[7:0];
      else if (reg_addr == ADDR_TIMER2_RELOAD_HIGH)
         rdata_next = reload2_reg[15:8];
      else if (reg_addr == ADDR_TIMER2_LOW_BYTE)
         rdata_next = count2_reg[7:0];
      else if (reg_addr == ADDR_TIMER2_HIGH_BYTE)
         rdata_next = count2_reg[15:8];
   end

   // Read data stands for one cycle after the strobe, zero otherwise
   always_ff @(posedge ref_clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
         reg_rdata <= 8'h00;
      else
         reg_rdata <= reg_rd ? rdata_next : 8'h00;
   end

endmodule : tcu_top

// ==== test/tcu_pin_model.sv ====
`timescale 1ns/1ps
module tcu_pin_model
(
   input wire logic ref_clk,
   output logic [2:0] cnt_pins,
   output logic [1:0] gate_pins,
   output logic dir_pin
);
   initial
   begin
      cnt_pins = 3'h7;
      gate_pins = 2'h3;
      dir_pin = 1'b1;
   end

   // One falling event, each level held well past the synchroniser depth
   task pulse(input int i);
      @(posedge ref_clk);
      cnt_pins[i] <= 1'b0;
      repeat (5) @(posedge ref_clk);
      cnt_pins[i] <= 1'b1;
      repeat (6) @(posedge ref_clk);
   endtask : pulse

   // Gate levels and direction, settled before the next event
   task level(input logic [1:0] g, input logic d);
      @(posedge ref_clk);
      gate_pins <= g;
      dir_pin <= d;
      repeat (5) @(posedge ref_clk);
   endtask : level
endmodule : tcu_pin_model

// ==== test/tcu_assertions.sv ====
`timescale 1ns/1ps
module tcu_assertions
   import tcu_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic [7:0] reg_rdata,
   input wire logic timer0_irq_ack,
   input wire logic timer1_irq_ack,
   input wire logic timer2_clock_pin_out,
   input wire logic timer2_clock_pin_oe_n,
   input wire logic timer0_irq,
   input wire logic timer1_irq,
   input wire logic timer2_irq,
   input wire logic timer2_baud_tick
);
   logic out_en_reg;
   logic ct2_reg;
   wire logic wr_timer2_control = reg_wr && reg_addr == ADDR_TIMER2_CONTROL;
   wire logic wr_tcon = reg_wr && reg_addr == ADDR_TIMER_CONTROL;
   wire logic clk_out_mode = out_en_reg && !ct2_reg;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   // Shadow of mode bits that only software writes
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         out_en_reg <= 1'b0;
         ct2_reg <= 1'b0;
      end
      else
      begin
         if (reg_wr && reg_addr == ADDR_TIMER2_MODE_CONTROL)
            out_en_reg <= reg_wdata[T2M_OUT_EN];
         if (wr_timer2_control)
            ct2_reg <= reg_wdata[T2C_COUNTER_SELECT];
      end
   end

   a_reset_zero: assert property (disable iff (1'b0) !rst_n |-> !timer0_irq && !timer1_irq
      && !timer2_irq && timer2_clock_pin_oe_n && reg_rdata == 8'h00)
      else $error("Outputs not cleared in reset");
   a_oe_mode: assert property (timer2_clock_pin_oe_n == !clk_out_mode)
      else $error("Pin enable does not follow clock-out mode");
   a_pin_quiet: assert property (timer2_clock_pin_oe_n && $past(timer2_clock_pin_oe_n)
      |-> !timer2_clock_pin_out)
      else $error("Clock-out pin active outside clock-out mode");
   a_clkout_noirq: assert property (clk_out_mode && !timer2_irq && !wr_timer2_control |=> !timer2_irq)
      else $error("Clock-out overflow raised an interrupt");
   a_baud_single: assert property (timer2_baud_tick |=> !timer2_baud_tick)
      else $error("Baud tick longer than one cycle");
   a_ack0_clear: assert property ($rose(timer0_irq_ack) |=> !timer0_irq)
      else $error("Timer 0 flag not cleared by acknowledge");
   a_ack1_clear: assert property ($rose(timer1_irq_ack) |=> !timer1_irq)
      else $error("Timer 1 flag not cleared by acknowledge");
   a_flag0_hold: assert property (timer0_irq && !timer0_irq_ack && !wr_tcon |=> timer0_irq)
      else $error("Timer 0 flag dropped without cause");
   a_flag2_hold: assert property (timer2_irq && !wr_timer2_control |=> timer2_irq)
      else $error("Timer 2 flag cleared by hardware");
endmodule : tcu_assertions

bind tcu_top tcu_assertions u_tcu_assertions (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata), .timer0_irq_ack(timer0_irq_ack),
   .timer1_irq_ack(timer1_irq_ack), .timer2_clock_pin_out(timer2_clock_pin_out),
   .timer2_clock_pin_oe_n(timer2_clock_pin_oe_n), .timer0_irq(timer0_irq), .timer1_irq(timer1_irq),
   .timer2_irq(timer2_irq), .timer2_baud_tick(timer2_baud_tick));

// ==== test/testbench.sv ====
`timescale 1ns/1ps
module testbench;
   logic ref_clk = 1'b0;
   logic rst_n;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [7:0] reg_rdata;
   logic [1:0] ack;
   logic [2:0] cnt_pins;
   logic [1:0] gate_pins;
   logic dir_pin;
   logic t2_out;
   logic t2_oe_n;
   logic [2:0] irq;
   logic baud_tick;
   logic rd_q = 1'b0;
   logic [7:0] exp_q[$];
   string name_q[$];
   int n_errors = 0;
   int n_compared = 0;
   int seed = 32'h3299;
   int n;
   logic [7:0] v;
   logic [7:0] regs[13] = '{8'h00, 8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'hc8, 8'hc9, 8'hca, 8'hcb,
      8'hcc, 8'hcd};
   wire logic t2_wire = t2_oe_n ? cnt_pins[2] : t2_out;

   always #25 ref_clk = ~ref_clk;

   tcu_top dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer0_irq_ack(ack[0]),
      .timer1_irq_ack(ack[1]), .ext_irq0_pin(gate_pins[0]), .ext_irq1_pin(gate_pins[1]),
      .timer0_count_pin(cnt_pins[0]), .timer1_count_pin(cnt_pins[1]), .timer2_clock_pin_in(t2_wire),
      .timer2_clock_pin_out(t2_out), .timer2_clock_pin_oe_n(t2_oe_n), .timer2_direction_pin(dir_pin),
      .timer0_irq(irq[0]), .timer1_irq(irq[1]), .timer2_irq(irq[2]), .timer2_baud_tick(baud_tick));

   tcu_pin_model pm (.ref_clk(ref_clk), .cnt_pins(cnt_pins), .gate_pins(gate_pins), .dir_pin(dir_pin));

   task chk(input string nm, input logic [7:0] seen, input logic [7:0] e);
      n_compared++;
      if (seen !== e)
      begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, seen);
      end
   endtask : chk

   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : wr

   task rd(input logic [7:0] a, input logic [7:0] e, input string nm);
      exp_q.push_back(e);
      name_q.push_back(nm);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
   endtask : rd

   task ack_irq(input int i);
      @(posedge ref_clk);
      ack[i] <= 1'b1;
      @(posedge ref_clk);
      ack[i] <= 1'b0;
      @(posedge ref_clk);
   endtask : ack_irq

   // Cycles between two rising samples of the clock-out pin or the baud tick
   task gap(input int s, output int k);
      logic p;
      logic c;
      int hits;
      hits = 0;
      k = 0;
      p = 1'b1;
      for (int j = 0; j < 200 && hits < 2; j++)
      begin
         @(posedge ref_clk);
         c = s ? baud_tick : t2_out;
         if (hits == 1)
            k++;
         if (!p && c)
            hits++;
         p = c;
      end
   endtask : gap

   task close_out;
      $display("Compared %0d, mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : close_out

   // Read data stands only in the cycle after the strobe
   always @(posedge ref_clk)
   begin
      if (rd_q)
         chk(name_q.pop_front(), reg_rdata, exp_q.pop_front());
      rd_q <= reg_rd;
   end

   initial
   begin
      repeat (20000) @(posedge ref_clk);
      n_errors++;
      close_out;
   end

   initial
   begin
      rst_n <= 1'b0;
      reg_addr <= 8'h00;
      reg_wdata <= 8'h00;
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      ack <= 2'h0;
      repeat (8) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
      foreach (regs[i])
         rd(regs[i], 8'h00, "reset");
      chk("oe_n", {7'h00, t2_oe_n}, 8'h01);
      v = 8'($random(seed));
      wr(8'h89, v);
      rd(8'h89, v, "timer_mode_control");
      wr(8'h89, 8'h05);
      wr(8'h8a, 8'hfe);
      wr(8'h8c, 8'hff);
      wr(8'h88, 8'h10);
      repeat (3) pm.pulse(0);
      rd(8'h8a, 8'h01, "tl0");
      rd(8'h8c, 8'h00, "th0");
      chk("irq0", {7'h00, irq[0]}, 8'h01);
      ack_irq(0);
      chk("irq0_ack", {7'h00, irq[0]}, 8'h00);
      wr(8'h89, 8'h0d);
      pm.level(2'h2, 1'b1);
      pm.pulse(0);
      rd(8'h8a, 8'h01, "gated");
      pm.level(2'h3, 1'b1);
      pm.pulse(0);
      rd(8'h8a, 8'h02, "ungated");
      wr(8'h89, 8'h04);
      wr(8'h8a, 8'h1f);
      wr(8'h8c, 8'h05);
      pm.pulse(0);
      rd(8'h8a, 8'h00, "tl0_m0");
      rd(8'h8c, 8'h06, "th0_m0");
      wr(8'h88, 8'h00);
      wr(8'h89, 8'h60);
      wr(8'h8d, v);
      wr(8'h8b, 8'hff);
      wr(8'h88, 8'h40);
      pm.pulse(1);
      rd(8'h8b, v, "tl1_reload");
      rd(8'h88, 8'hc0, "tcon");
      ack_irq(1);
      chk("irq1_ack", {7'h00, irq[1]}, 8'h00);
      wr(8'h89, 8'h70);
      pm.pulse(1);
      rd(8'h8b, v, "tl1_halt");
      wr(8'h88, 8'h00);
      wr(8'h89, 8'h03);
      wr(8'h8c, 8'hff);
      wr(8'h88, 8'h40);
      repeat (10) @(posedge ref_clk);
      rd(8'h88, 8'hc0, "split_tf1");
      rd(8'h8a, 8'h00, "split_tl0");
      wr(8'h88, 8'h00);
      wr(8'h89, 8'h01);
      wr(8'h8a, 8'h00);
      wr(8'h8c, 8'h00);
      wr(8'h88, 8'h10);
      repeat (58) @(posedge ref_clk);
      wr(8'h88, 8'h00);
      rd(8'h8a, 8'h0a, "div6");
      wr(8'hc8, 8'h02);
      wr(8'hca, 8'h34);
      wr(8'hcb, 8'h12);
      wr(8'hcc, 8'hfe);
      wr(8'hcd, 8'hff);
      wr(8'hc8, 8'h06);
      repeat (2) pm.pulse(2);
      rd(8'hcc, 8'h34, "tl2");
      rd(8'hcd, 8'h12, "th2");
      rd(8'hc8, 8'h86, "timer2_control");
      chk("irq2", {7'h00, irq[2]}, 8'h01);
      wr(8'hc8, 8'h02);
      pm.pulse(2);
      rd(8'hcc, 8'h34, "t2_stop");
      wr(8'hc9, 8'h01);
      pm.level(2'h3, 1'b0);
      wr(8'hcc, 8'h35);
      wr(8'hc8, 8'h06);
      repeat (2) pm.pulse(2);
      rd(8'hcc, 8'hff, "t2_under");
      rd(8'hc8, 8'hc6, "t2_ext");
      pm.level(2'h3, 1'b1);
      pm.pulse(2);
      rd(8'hcd, 8'h12, "t2_up");
      rd(8'hc8, 8'h86, "t2_ext_back");
      wr(8'hc9, 8'h00);
      wr(8'hcc, 8'h00);
      wr(8'hcd, 8'h00);
      wr(8'hc8, 8'h04);
      repeat (58) @(posedge ref_clk);
      wr(8'hc8, 8'h00);
      rd(8'hcc, 8'h0a, "t2_div6");
      wr(8'hc8, 8'h00);
      wr(8'hc9, 8'h02);
      wr(8'hca, 8'hfc);
      wr(8'hcb, 8'hff);
      wr(8'hcc, 8'hfc);
      wr(8'hcd, 8'hff);
      wr(8'hc8, 8'h14);
      chk("oe_n_on", {7'h00, t2_oe_n}, 8'h00);
      gap(0, n);
      chk("clk_period", 8'(n), 8'h10);
      gap(1, n);
      chk("baud_gap", 8'(n), 8'h08);
      chk("irq2_clkout", {7'h00, irq[2]}, 8'h00);
      wr(8'hc9, 8'h00);
      repeat (4) @(posedge ref_clk);
      close_out;
   end
endmodule : testbench
